// [prog_read_pkg.sv]
// Constants, register map and state codes for the program memory read unit.
// Assumes a single 20 MHz clock domain shared with the processor core.
// What this block does
// - Memory access happens in second instruction cycle after.
// - Second instruction after trigger is suppressed.
// - Fetched word lands in data bytes next cycle.
// - Data bytes hold until next read or write.
// - Reading still works under code protection.
package prog_read_pkg;

  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int BUS_ADDR_W = 5;
  localparam int WORD_W = 14;
  localparam int DATA_HIGH_W = WORD_W - 8;
  localparam int SYNC_STAGES = 3;

  // Byte addresses on the register bus, one aligned word each.
  localparam logic [BUS_ADDR_W-1:0] OFS_ADDR_LOW = 5'h00;
  localparam logic [BUS_ADDR_W-1:0] OFS_ADDR_HIGH = 5'h04;
  localparam logic [BUS_ADDR_W-1:0] OFS_READ_CTRL = 5'h08;
  localparam logic [BUS_ADDR_W-1:0] OFS_DATA_LOW = 5'h0C;
  localparam logic [BUS_ADDR_W-1:0] OFS_DATA_HIGH = 5'h10;

  // Fields of the read control register.
  localparam int CTRL_RD_BIT = 0;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CTRL_PROT_BIT = 2;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [DATA_HIGH_W-1:0] RST_DATA_HIGH = 6'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Number of the instruction pulse after the trigger that carries the access slot.
  localparam logic [1:0] ACCESS_SLOT = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT1 = 4'h2,
    ST_WAIT2 = 4'h4,
    ST_CAPTURE = 4'h8
  } rd_state_e;

endpackage

// [level_sync.sv]
// Three-stage synchroniser with agreement filter for a slow level from a pin.
// Assumes the input changes far slower than the clock.
`timescale 1ns/1ps
module level_sync
  import prog_read_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Level in and filtered level out.
  input wire logic level_in,
  output logic level_out
);

  logic [SYNC_STAGES-1:0] stage_r;
  logic [SYNC_STAGES-1:0] stage_nxt;
  logic level_r;
  logic level_nxt;

  always_comb begin
    stage_nxt = {stage_r[SYNC_STAGES-2:0], level_in};
    level_nxt = level_r;
    // Only the later two stages are compared; the first may be metastable.
    if (stage_r[1] == stage_r[2]) begin
      level_nxt = stage_r[2];
    end
  end

  genvar i;
  generate
    for (i = 0; i < SYNC_STAGES; i++) begin : g_stage
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stage_r[i] <= 1'b0;
        end else begin
          stage_r[i] <= stage_nxt[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;

endmodule

// [prog_read_controller.sv]
// Program memory read unit: address and data registers, read sequencer.
// Assumes the core pulses INSTR_CYCLE once per instruction and that the
// memory answers MEM_RDATA one clock after MEM_RD.
`timescale 1ns/1ps
module prog_read_controller
  import prog_read_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Avalon-MM slave.
  input wire logic [BUS_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Core pipeline.
  input wire logic INSTR_CYCLE,
  output logic INSTR_SUPPRESS,
  // Program memory.
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD,
  input wire logic [WORD_W-1:0] MEM_RDATA,
  // Code protection fuse level.
  input wire logic CODE_PROTECT
);

  function automatic logic reg_hit(input logic [BUS_ADDR_W-1:0] a, input logic [BUS_ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  rd_state_e state_r;
  rd_state_e state_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [7:0] addr_low_r;
  logic [7:0] addr_low_nxt;
  logic [7:0] addr_high_r;
  logic [7:0] addr_high_nxt;
  logic [7:0] data_low_r;
  logic [7:0] data_low_nxt;
  logic [DATA_HIGH_W-1:0] data_high_r;
  logic [DATA_HIGH_W-1:0] data_high_nxt;
  logic rd_bit_r;
  logic rd_bit_nxt;
  logic protect;
  logic req;
  logic wr_go;
  logic lane0;
  logic access;

  // Protection status is only reported; it never blocks the core's read.
  level_sync u_prot_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .level_in(CODE_PROTECT),
    .level_out(protect)
  );

  assign req = AVS_READ | AVS_WRITE;
  assign wr_go = AVS_WRITE & ack_r;
  assign lane0 = AVS_BYTEENABLE[0];
  assign access = (state_r == ST_WAIT2) & INSTR_CYCLE;

  // Bus handshake: one wait cycle, then the access completes.
  always_comb begin
    ack_nxt = req & ~ack_r;
    rdata_nxt = rdata_r;
    if (AVS_READ & ~ack_r) begin
      rdata_nxt = RST_WORD;
      if (reg_hit(AVS_ADDRESS, OFS_ADDR_LOW)) begin
        rdata_nxt[7:0] = addr_low_r;
      end else if (reg_hit(AVS_ADDRESS, OFS_ADDR_HIGH)) begin
        rdata_nxt[7:0] = addr_high_r;
      end else if (reg_hit(AVS_ADDRESS, OFS_READ_CTRL)) begin
        rdata_nxt[CTRL_RD_BIT] = rd_bit_r;
        rdata_nxt[CTRL_BUSY_BIT] = (state_r != ST_IDLE);
        rdata_nxt[CTRL_PROT_BIT] = protect;
      end else if (reg_hit(AVS_ADDRESS, OFS_DATA_LOW)) begin
        rdata_nxt[7:0] = data_low_r;
      end else if (reg_hit(AVS_ADDRESS, OFS_DATA_HIGH)) begin
        rdata_nxt[DATA_HIGH_W-1:0] = data_high_r;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_r <= 1'b0;
      rdata_r <= RST_WORD;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign AVS_WAITREQUEST = req & ~ack_r;
  assign AVS_READDATA = rdata_r;

  // Registers and read sequencer.
  always_comb begin
    state_nxt = state_r;
    rd_bit_nxt = rd_bit_r;
    addr_low_nxt = addr_low_r;
    addr_high_nxt = addr_high_r;
    data_low_nxt = data_low_r;
    data_high_nxt = data_high_r;
    if (wr_go & lane0) begin
      if (reg_hit(AVS_ADDRESS, OFS_ADDR_LOW)) begin
        addr_low_nxt = AVS_WRITEDATA[7:0];
      end
      if (reg_hit(AVS_ADDRESS, OFS_ADDR_HIGH)) begin
        addr_high_nxt = AVS_WRITEDATA[7:0];
      end
      if (reg_hit(AVS_ADDRESS, OFS_DATA_LOW)) begin
        data_low_nxt = AVS_WRITEDATA[7:0];
      end
      if (reg_hit(AVS_ADDRESS, OFS_DATA_HIGH)) begin
        data_high_nxt = AVS_WRITEDATA[DATA_HIGH_W-1:0];
      end
    end
    case (state_r)
      ST_IDLE: begin
        // Software can only set the trigger; clearing is left to hardware.
        if (wr_go & lane0 & reg_hit(AVS_ADDRESS, OFS_READ_CTRL) & AVS_WRITEDATA[CTRL_RD_BIT]) begin
          rd_bit_nxt = 1'b1;
          state_nxt = ST_WAIT1;
        end
      end
      ST_WAIT1: begin
        if (INSTR_CYCLE) begin
          state_nxt = ST_WAIT2;
        end
      end
      ST_WAIT2: begin
        if (INSTR_CYCLE) begin
          state_nxt = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        // The fetched word wins over a same-cycle software write.
        data_low_nxt = MEM_RDATA[7:0];
        data_high_nxt = MEM_RDATA[WORD_W-1:8];
        rd_bit_nxt = 1'b0;
        state_nxt = ST_IDLE;
      end
      default: begin
        rd_bit_nxt = 1'b0;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= ST_IDLE;
      rd_bit_r <= 1'b0;
      addr_low_r <= RST_BYTE;
      addr_high_r <= RST_BYTE;
      data_low_r <= RST_BYTE;
      data_high_r <= RST_DATA_HIGH;
    end else begin
      state_r <= state_nxt;
      rd_bit_r <= rd_bit_nxt;
      addr_low_r <= addr_low_nxt;
      addr_high_r <= addr_high_nxt;
      data_low_r <= data_low_nxt;
      data_high_r <= data_high_nxt;
    end
  end

  // The access slot is taken from the core, so its instruction is killed.
  assign MEM_RD = access;
  assign INSTR_SUPPRESS = access;
  assign MEM_ADDR = {addr_high_r, addr_low_r};

  // Helper: instruction pulses seen since the trigger was set.
  logic [1:0] pulse_cnt_r;
  logic [1:0] pulse_cnt_nxt;

  always_comb begin
    pulse_cnt_nxt = pulse_cnt_r;
    if (state_r == ST_IDLE) begin
      pulse_cnt_nxt = 2'h0;
    end else if (INSTR_CYCLE && pulse_cnt_r != 2'h3) begin
      pulse_cnt_nxt = pulse_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pulse_cnt_r <= 2'h0;
    end else begin
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_fetch;
    MEM_RD ##1 (state_r == ST_CAPTURE);
  endsequence

  a_access_second_slot: assert property (MEM_RD |-> (pulse_cnt_r == ACCESS_SLOT - 2'h1) && INSTR_CYCLE)
    else $error("Access not in second instruction cycle after trigger.");
  a_trigger_starts_wait: assert property ((state_r == ST_IDLE) && wr_go && lane0 &&
      reg_hit(AVS_ADDRESS, OFS_READ_CTRL) && AVS_WRITEDATA[CTRL_RD_BIT] |=> (state_r == ST_WAIT1) && rd_bit_r)
    else $error("Trigger write did not start the read.");
  a_suppress_with_access: assert property (INSTR_SUPPRESS |-> MEM_RD && (state_r == ST_WAIT2))
    else $error("Suppress without memory access.");
  a_data_loads_next: assert property (s_fetch |=> (data_low_r == $past(MEM_RDATA[7:0])) &&
      (data_high_r == $past(MEM_RDATA[WORD_W-1:8])))
    else $error("Fetched word not in data registers.");
  a_data_holds_value: assert property ((state_r != ST_CAPTURE) && !wr_go |=> $stable(data_low_r) && $stable(data_high_r))
    else $error("Data registers changed without cause.");
  a_protect_no_block: assert property ((state_r == ST_WAIT2) && INSTR_CYCLE && protect |-> MEM_RD)
    else $error("Read blocked under code protection.");
  a_trigger_self_clear: assert property ((state_r == ST_CAPTURE) |=> !rd_bit_r && (state_r == ST_IDLE))
    else $error("Trigger bit not cleared after capture.");
  a_trigger_held_busy: assert property ((state_r != ST_IDLE) |-> rd_bit_r)
    else $error("Trigger bit dropped during read.");
  a_bus_wait_one: assert property (AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("Wait request longer than one cycle.");

endmodule

// [core_mem_model.sv]
// Stand-in for the core pipeline and the program memory behind the read unit.
// Assumes the read unit raises MEM_RD for one clock per access.
`timescale 1ns/1ps
module core_mem_model (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Memory request from the read unit.
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  // Core pulse and memory word.
  output logic INSTR_CYCLE,
  output logic [13:0] MEM_RDATA
);
  logic [1:0] phase_r;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_r <= 2'h0;
      MEM_RDATA <= 14'h0000;
    end else begin
      phase_r <= phase_r + 2'h1;
      // The word is valid only in the clock after the strobe; it toggles otherwise.
      MEM_RDATA <= MEM_RD ? (MEM_ADDR[13:0] ^ 14'h1A5C) : ~MEM_RDATA;
    end
  end

  // One instruction every four clocks, as a core running on quarter cycles.
  assign INSTR_CYCLE = (phase_r == 2'h3);
endmodule

// [test_prog_read_controller.sv]
// Self-checking bench for the program memory read unit.
// Assumes the core and memory stand-in of core_mem_model on the far side.
`timescale 1ns/1ps
module test_prog_read_controller
  import prog_read_pkg::*;
;
  logic clk = 0, rst = 1, rd = 0, wr = 0, prot = 0;
  logic [BUS_ADDR_W-1:0] adr = 0;
  logic [3:0] be = 0;
  logic [31:0] wdata = 0, rdata, q;
  logic wait_req, instr, supp, mrd, sup_seen;
  logic [15:0] maddr, addr_seen;
  logic [13:0] mdata;
  int n_fail = 0, checks_done = 0, pulses = 0, rd_at = 0, rd_n = 0, sup_n = 0;

  always #25 clk = ~clk;

  prog_read_controller u_prog_read_controller (.CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .INSTR_CYCLE(instr), .INSTR_SUPPRESS(supp), .MEM_ADDR(maddr),
    .MEM_RD(mrd), .MEM_RDATA(mdata), .CODE_PROTECT(prot));
  core_mem_model u_core_mem_model (.CLK(clk), .SYS_RST(rst), .MEM_ADDR(maddr), .MEM_RD(mrd),
    .INSTR_CYCLE(instr), .MEM_RDATA(mdata));

  // Counts instruction pulses since the last control write and notes the access.
  always @(negedge clk) begin
    pulses = pulses + int'(instr);
    sup_n = sup_n + int'(supp);
    if (mrd) begin
      rd_n = rd_n + 1;
      rd_at = pulses;
      sup_seen = supp & instr;
      addr_seen = maddr;
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Waitrequest and read data are taken at the rising edge; only the watchdog ends a hung wait.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    be <= b;
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    rd <= 0;
    wr <= 0;
    if (w && a == OFS_READ_CTRL) begin
      pulses = 0;
      rd_n = 0;
      sup_n = 0;
    end
    @(posedge clk);
  endtask

  task do_read(input logic [15:0] a);
    int k;
    logic [13:0] e;
    logic busy_seen;
    e = a[13:0] ^ 14'h1A5C;
    busy_seen = 1'b0;
    bus(1, OFS_ADDR_LOW, 32'(a[7:0]), 4'h1);
    bus(1, OFS_ADDR_HIGH, 32'(a[15:8]), 4'h1);
    bus(1, OFS_READ_CTRL, 32'h0000_0001, 4'h1);
    k = 0;
    do begin
      bus(0, OFS_READ_CTRL, 0, 4'hF);
      if (k == 0) busy_seen = q[CTRL_BUSY_BIT];
      k++;
    end while (q[CTRL_RD_BIT] !== 1'b0 && k < 20);
    check("busy during read", 32'(busy_seen), 1);
    check("busy after read", 32'(q[CTRL_BUSY_BIT]), 0);
    check("trigger clear", 32'(q[CTRL_RD_BIT]), 0);
    check("access pulse", rd_at, 2);
    check("access count", rd_n, 1);
    check("suppress", 32'({sup_seen, 4'(sup_n)}), 32'h0000_0011);
    check("mem addr", 32'(addr_seen), 32'(a));
    bus(0, OFS_DATA_LOW, 0, 4'hF);
    check("data low", q, 32'(e[7:0]));
    bus(0, OFS_DATA_HIGH, 0, 4'hF);
    check("data high", q, 32'(e[13:8]));
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      bus(0, 5'(4 * i), 0, 4'hF);
      check("reset value", q, 0);
    end
    bus(1, 5'h14, 32'h0000_00FF, 4'hF);
    bus(0, 5'h14, 0, 4'hF);
    check("unmapped", q, 0);
    // Clear trigger with read-only bits set must neither start a read nor stick.
    bus(1, OFS_READ_CTRL, 32'h0000_0006, 4'h1);
    repeat (20) @(posedge clk);
    check("no access", rd_n, 0);
    bus(0, OFS_READ_CTRL, 0, 4'hF);
    check("ctrl ro", q, 0);
    do_read(16'h0ABC);
    do_read(16'h0F01);
    bus(1, OFS_DATA_LOW, 32'h0000_005A, 4'h0);
    bus(0, OFS_DATA_LOW, 0, 4'hF);
    check("hold low", q, 32'h0000_005D);
    bus(1, OFS_DATA_LOW, 32'h0000_003C, 4'h1);
    repeat (50) @(posedge clk);
    bus(0, OFS_DATA_LOW, 0, 4'hF);
    check("sw low", q, 32'h0000_003C);
    bus(0, OFS_DATA_HIGH, 0, 4'hF);
    check("hold high", q, 32'h0000_0015);
    prot <= 1;
    repeat (10) @(posedge clk);
    bus(0, OFS_READ_CTRL, 0, 4'hF);
    check("protect bit", 32'(q[CTRL_PROT_BIT]), 1);
    do_read(16'h0123);
    end_sim;
  end

  initial begin
    #100_000;
    n_fail++;
    end_sim;
  end
endmodule
